/* File: hw/ctr_defines.svh */
// Purpose: Offsets, field positions and reset values of the converter
//          threshold register bank.
// Assumes: Included by its bare name from the package only; the modules do not include it.
// Notes:   Definitions only; there is no logic in this file.
`ifndef CTR_DEFINES_SVH
`define CTR_DEFINES_SVH

// Register indices on the configuration port
`define CTR_IDX_SLOPE       2'h0
`define CTR_IDX_UV_RISE     2'h1
`define CTR_IDX_UV_FALL     2'h2
`define CTR_IDX_OV_RISE     2'h3

// Register and code widths
`define CTR_REG_W           16
`define CTR_CODE_W          10

// Byte lanes of a 16-bit register
`define CTR_HI_MSB          15
`define CTR_HI_LSB          8
`define CTR_LO_MSB          7
`define CTR_LO_LSB          0
`define CTR_BE_HI           1
`define CTR_BE_LO           0

// Threshold code placement: code 9..2 in 15..8, code 1..0 in 7..6
`define CTR_THR_TOP_MSB     15
`define CTR_THR_TOP_LSB     8
`define CTR_THR_BOT_MSB     7
`define CTR_THR_BOT_LSB     6
`define CTR_CODE_TOP_MSB    9
`define CTR_CODE_TOP_LSB    2
`define CTR_CODE_BOT_MSB    1
`define CTR_CODE_BOT_LSB    0
`define CTR_THR_PAD         6'h00

// Power-on values, as whole register words
`define CTR_SLOPE_RST       16'h1526
`define CTR_UV_RISE_RST     16'h2500
`define CTR_UV_FALL_RST     16'h2280
`define CTR_OV_RISE_RST     16'hFC80

`define CTR_ZERO_WORD       16'h0000
`define CTR_ZERO_CODE       10'h000

`endif

/* File: hw/ctr_pkg.sv */
// Purpose: Types and shared helpers of the converter threshold registers.
// Assumes: ctr_defines.svh supplies every number used here.
// Notes:   The byte merge is shared by the slope and threshold registers.
`include "ctr_defines.svh"

package ctr_pkg;

	// Register selector on the configuration port
	typedef enum logic [1:0] {
		CTR_SEL_SLOPE   = `CTR_IDX_SLOPE,
		CTR_SEL_UV_RISE = `CTR_IDX_UV_RISE,
		CTR_SEL_UV_FALL = `CTR_IDX_UV_FALL,
		CTR_SEL_OV_RISE = `CTR_IDX_OV_RISE
	} ctr_sel_t;

	// One access from the serial configuration engine
	typedef struct packed {
		logic                    wr;
		logic                    rd;
		ctr_sel_t                sel;
		logic [1:0]              be;
		logic [`CTR_REG_W-1:0]   wdata;
	} ctr_req_t;

	// Threshold codes handed to the input monitor comparators
	typedef struct packed {
		logic [`CTR_CODE_W-1:0]  uv_rise;
		logic [`CTR_CODE_W-1:0]  uv_fall;
		logic [`CTR_CODE_W-1:0]  ov_rise;
	} ctr_thr_t;

	// Replace only the byte lanes that are enabled
	function automatic logic [`CTR_REG_W-1:0] ctr_merge(
		input logic [`CTR_REG_W-1:0] old_word,
		input logic [`CTR_REG_W-1:0] new_word,
		input logic [1:0]            be
	);
		logic [`CTR_REG_W-1:0] res;
		res = old_word;
		if (be[`CTR_BE_HI]) begin
			res[`CTR_HI_MSB:`CTR_HI_LSB] = new_word[`CTR_HI_MSB:`CTR_HI_LSB];
		end
		if (be[`CTR_BE_LO]) begin
			res[`CTR_LO_MSB:`CTR_LO_LSB] = new_word[`CTR_LO_MSB:`CTR_LO_LSB];
		end
		return res;
	endfunction

endpackage

/* File: hw/ctr_thr_reg.sv */
// Purpose: One input voltage threshold register holding a 10-bit code.
// Assumes: Write strobe and byte enables come from the same clock domain.
// Notes:   Only the ten code bits are stored; the six low bits do not exist.
`timescale 1ns/10ps

module ctr_thr_reg
	import ctr_pkg::*;
#(
	parameter logic [`CTR_REG_W-1:0] RESET_WORD = `CTR_ZERO_WORD
) (
	input  wire logic                   clk_sys_in,
	input  wire logic                   rstn_in,
	input  wire logic                   wr_in,
	input  wire logic [1:0]             be_in,
	input  wire logic [`CTR_REG_W-1:0]  wdata_in,
	output logic      [`CTR_CODE_W-1:0] code_out,
	output logic      [`CTR_REG_W-1:0]  word_out
);

	logic [`CTR_CODE_W-1:0] code_r;
	logic [`CTR_CODE_W-1:0] code_nxt;
	logic [`CTR_REG_W-1:0]  merged;
	logic [`CTR_CODE_W-1:0] reset_code;

	// Reset word folded back into code form
	assign reset_code = {RESET_WORD[`CTR_THR_TOP_MSB:`CTR_THR_TOP_LSB],
	                     RESET_WORD[`CTR_THR_BOT_MSB:`CTR_THR_BOT_LSB]};

	// Word view: code 9..2 high byte, code 1..0 at 7..6, rest zero
	assign word_out = {code_r[`CTR_CODE_TOP_MSB:`CTR_CODE_TOP_LSB],
	                   code_r[`CTR_CODE_BOT_MSB:`CTR_CODE_BOT_LSB],
	                   `CTR_THR_PAD}; // (R2) (R3) (R5) (R7)

	// Byte merge against the word view, then strip the dead bits
	assign merged   = ctr_merge(word_out, wdata_in, be_in);
	assign code_nxt = wr_in ? {merged[`CTR_THR_TOP_MSB:`CTR_THR_TOP_LSB],
	                           merged[`CTR_THR_BOT_MSB:`CTR_THR_BOT_LSB]}
	                        : code_r; // (R3)

	// Code storage
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			code_r <= reset_code;
		end else begin
			code_r <= code_nxt;
		end
	end

	assign code_out = code_r;

endmodule

/* File: hw/ctr_threshold_regs.sv */
// Purpose: Slope compensation and input voltage threshold registers of a
//          digitally controlled buck-boost converter.
// Assumes: The serial configuration engine runs on clk_sys_in and presents
//          at most one access per cycle; the enable level is synchronous.
// Notes:   Read data is registered and appears one cycle after the request.
`timescale 1ns/10ps

// Functional notes
// (R1) Slope register: 16-bit read/write, high byte 15..8, low byte 7..0.
// (R2) Undervoltage rising code: bits 9..2 at 15..8, bits 1..0 at 7..6.
// (R3) Threshold register bits 5..0 read zero; writes to them do nothing.
// (R4) Undervoltage rising register resets to 0x2500.
// (R5) Undervoltage falling code: bits 9..2 at 15..8, bits 1..0 at 7..6.
// (R6) Undervoltage falling register resets to 0x2280.
// (R7) Overvoltage rising code: bits 9..2 at 15..8, bits 1..0 at 7..6.
// (R8) Overvoltage rising register resets to 0xFC80.
// (R9) Software codes a threshold as volts times 1024 over 40.96.
// (R10) Slope register resets to its per-bit defaults, 0x1526.
module ctr_threshold_regs
	import ctr_pkg::*;
(
	input  wire logic                   clk_sys_in,
	input  wire logic                   rstn_in,
	input  wire ctr_req_t               req_in,
	input  wire logic                   conv_enabled_in,
	output logic                        ack_out,
	output logic                        rvalid_out,
	output logic      [`CTR_REG_W-1:0]  rdata_out,
	output logic                        wr_blocked_out,
	output logic      [`CTR_REG_W-1:0]  slope_comp_out,
	output ctr_thr_t                    thresholds_out
);

	// Decoded write strobes
	wire                    hit_slope;
	wire                    hit_uv_rise;
	wire                    hit_uv_fall;
	wire                    hit_ov_rise;
	wire                    slope_locked;
	wire                    slope_wr;
	wire [`CTR_REG_W-1:0]   uv_rise_word;
	wire [`CTR_REG_W-1:0]   uv_fall_word;
	wire [`CTR_REG_W-1:0]   ov_rise_word;
	wire [`CTR_REG_W-1:0]   read_mux;

	logic [`CTR_REG_W-1:0]  slope_r;
	logic [`CTR_REG_W-1:0]  slope_nxt;
	logic [`CTR_REG_W-1:0]  rdata_r;
	logic [`CTR_REG_W-1:0]  rdata_nxt;
	logic                   rvalid_r;
	logic                   blocked_r;
	logic                   blocked_nxt;

	// Address decode; the two-bit selector has no unmapped value
	assign hit_slope   = req_in.wr && (req_in.sel == CTR_SEL_SLOPE);
	assign hit_uv_rise = req_in.wr && (req_in.sel == CTR_SEL_UV_RISE);
	assign hit_uv_fall = req_in.wr && (req_in.sel == CTR_SEL_UV_FALL);
	assign hit_ov_rise = req_in.wr && (req_in.sel == CTR_SEL_OV_RISE);

	// The loop reads slope every cycle, so changing it live would upset
	// regulation; writes are dropped while the converter runs.
	assign slope_locked = conv_enabled_in;
	assign slope_wr     = hit_slope && !slope_locked;

	// Slope compensation word, byte lanes as written
	assign slope_nxt = slope_wr ? ctr_merge(slope_r, req_in.wdata, req_in.be)
	                            : slope_r; // (R1)

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			slope_r <= `CTR_SLOPE_RST; // (R10)
		end else begin
			slope_r <= slope_nxt;
		end
	end

	// Undervoltage rising threshold
	ctr_thr_reg #(
		.RESET_WORD (`CTR_UV_RISE_RST) // (R4)
	) u_uv_rise (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.wr_in      (hit_uv_rise), // (R2)
		.be_in      (req_in.be),
		.wdata_in   (req_in.wdata),
		.code_out   (thresholds_out.uv_rise),
		.word_out   (uv_rise_word)
	);

	// Undervoltage falling threshold
	ctr_thr_reg #(
		.RESET_WORD (`CTR_UV_FALL_RST) // (R6)
	) u_uv_fall (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.wr_in      (hit_uv_fall), // (R5)
		.be_in      (req_in.be),
		.wdata_in   (req_in.wdata),
		.code_out   (thresholds_out.uv_fall),
		.word_out   (uv_fall_word)
	);

	// Overvoltage rising threshold
	ctr_thr_reg #(
		.RESET_WORD (`CTR_OV_RISE_RST) // (R8)
	) u_ov_rise (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.wr_in      (hit_ov_rise), // (R7)
		.be_in      (req_in.be),
		.wdata_in   (req_in.wdata),
		.code_out   (thresholds_out.ov_rise),
		.word_out   (ov_rise_word)
	);

	// Read selection; threshold words already carry zero low bits
	assign read_mux = (req_in.sel == CTR_SEL_SLOPE)   ? slope_r      :
	                  (req_in.sel == CTR_SEL_UV_RISE) ? uv_rise_word :
	                  (req_in.sel == CTR_SEL_UV_FALL) ? uv_fall_word :
	                                                    ov_rise_word; // (R3)

	// Read data holds its last value between reads
	assign rdata_nxt   = req_in.rd ? read_mux : rdata_r;
	assign blocked_nxt = hit_slope && slope_locked;

	// Read and status flops
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			rdata_r   <= `CTR_ZERO_WORD;
			rvalid_r  <= 1'b0;
			blocked_r <= 1'b0;
		end else begin
			rdata_r   <= rdata_nxt;
			rvalid_r  <= req_in.rd;
			blocked_r <= blocked_nxt;
		end
	end

	// Every access is taken in the cycle it is presented
	assign ack_out        = req_in.wr || req_in.rd;
	assign rvalid_out     = rvalid_r;
	assign rdata_out      = rdata_r;
	assign wr_blocked_out = blocked_r;
	assign slope_comp_out = slope_r;

endmodule

/* File: verification/ctr_threshold_regs_sva.sv */
// Purpose: Port properties of the threshold register bank.
// Assumes: One clock domain; reset is synchronous, active low.
// Notes:   Full-lane writes only drive the write properties.
`timescale 1ns/10ps

module ctr_threshold_regs_sva
	import ctr_pkg::*;
(
	input wire logic        clk_sys_in,
	input wire logic        rstn_in,
	input wire ctr_req_t    req_in,
	input wire logic        conv_enabled_in,
	input wire logic [15:0] rdata_out,
	input wire logic [15:0] slope_comp_out,
	input wire ctr_thr_t    thresholds_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);

	// Both lanes written in one access; partial writes merge old bytes
	wire logic        full_wr = req_in.wr && req_in.be == 2'h3;
	wire logic [15:0] wr_word = req_in.wdata;
	wire logic [9:0]  wr_code = req_in.wdata[15:6];

	// Reset words, read back as codes on the monitor outputs, and the slope word on slope_comp_out
	a_uvr_reset_code: assert property ($rose(rstn_in) |-> thresholds_out.uv_rise == 10'h094)
		else $error("uv rise reset code wrong");
	a_uvf_reset_code: assert property ($rose(rstn_in) |-> thresholds_out.uv_fall == 10'h08A)
		else $error("uv fall reset code wrong");
	a_ovr_reset_code: assert property ($rose(rstn_in) |-> thresholds_out.ov_rise == 10'h3F2)
		else $error("ov rise reset code wrong");
	a_slope_reset_word: assert property ($rose(rstn_in) |-> slope_comp_out == 16'h1526)
		else $error("slope reset word wrong");
	// Written code appears after the taking edge
	a_uvr_write_code: assert property (full_wr && req_in.sel == CTR_SEL_UV_RISE
		|=> thresholds_out.uv_rise == $past(wr_code)) else $error("uv rise code not stored");
	a_uvf_write_code: assert property (full_wr && req_in.sel == CTR_SEL_UV_FALL
		|=> thresholds_out.uv_fall == $past(wr_code)) else $error("uv fall code not stored");
	a_ovr_write_code: assert property (full_wr && req_in.sel == CTR_SEL_OV_RISE
		|=> thresholds_out.ov_rise == $past(wr_code)) else $error("ov rise code not stored");
	a_slope_write_word: assert property (full_wr && req_in.sel == CTR_SEL_SLOPE
		&& !conv_enabled_in |=> slope_comp_out == $past(wr_word)) else $error("slope not stored");
	// Pad bits of threshold reads never carry data
	a_pad_read_zero: assert property (req_in.rd && req_in.sel != CTR_SEL_SLOPE
		|=> rdata_out[5:0] == 6'h00) else $error("threshold pad bits not zero");
endmodule

bind ctr_threshold_regs ctr_threshold_regs_sva u_sva (.clk_sys_in, .rstn_in, .req_in,
	.conv_enabled_in, .rdata_out, .slope_comp_out, .thresholds_out);

/* File: verification/testbench.sv */
// Purpose: Self-checking bench of the threshold register bank.
// Assumes: Answers land on the taking edge and are checked 1 ns after it.
// Notes:   Inputs change 1 ns after a rising edge.
`timescale 1ns/10ps

module testbench
	import ctr_pkg::*;
;
	logic          clk_sys_in = 1'b0;
	logic          rstn_in = 1'b0;
	ctr_req_t      req_in = '0;
	logic          conv_enabled_in = 1'b0;
	logic          ack_out;
	logic          rvalid_out;
	logic          wr_blocked_out;
	logic [15:0]   rdata_out;
	logic [15:0]   slope_comp_out;
	ctr_thr_t      thresholds_out;
	int            failures = 0;
	int            total_checks = 0;

	// 125 MHz clock
	always #4 clk_sys_in = ~clk_sys_in;

	ctr_threshold_regs dut (.clk_sys_in, .rstn_in, .req_in, .conv_enabled_in, .ack_out,
		.rvalid_out, .rdata_out, .wr_blocked_out, .slope_comp_out, .thresholds_out);

	// Case equality so an unknown never matches
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Request held across exactly one taking edge; pulses must be gone when idle
	task automatic acc(input logic w, input logic r, input ctr_sel_t s, input logic [1:0] b,
		input logic [15:0] d);
		@(posedge clk_sys_in);
		#1;
		chk(16'(ack_out), 16'h0000);
		chk(16'(rvalid_out), 16'h0000);
		chk(16'(wr_blocked_out), 16'h0000);
		req_in = '{wr: w, rd: r, sel: s, be: b, wdata: d};
		#1;
		chk(16'(ack_out), 16'(w | r));
		@(posedge clk_sys_in);
		#1;
		req_in = '0;
	endtask

	task automatic rd(input ctr_sel_t s, input logic [15:0] exp);
		acc(1'b0, 1'b1, s, 2'h0, 16'h0000);
		chk(16'(rvalid_out), 16'h0001);
		chk(rdata_out, exp);
	endtask

	// Eight edges of reset; the request may follow one edge later
	task automatic do_reset();
		rstn_in = 1'b0;
		repeat (8) @(posedge clk_sys_in);
		#1;
		rstn_in = 1'b1;
	endtask

	task automatic t_defaults();
		rd(CTR_SEL_SLOPE, 16'h1526);
		rd(CTR_SEL_UV_RISE, 16'h2500);
		rd(CTR_SEL_UV_FALL, 16'h2280);
		rd(CTR_SEL_OV_RISE, 16'hFC80);
	endtask

	// All ones, then high lane only; pad bits must drop out
	task automatic t_thresholds();
		ctr_sel_t s;
		for (int i = 1; i < 4; i++) begin
			s = ctr_sel_t'(i);
			acc(1'b1, 1'b0, s, 2'h3, 16'hFFFF);
			rd(s, 16'hFFC0);
			acc(1'b1, 1'b0, s, 2'h2, 16'h5A00);
			rd(s, 16'h5AC0);
		end
		chk(16'(thresholds_out.uv_rise), 16'h016B);
		chk(16'(thresholds_out.uv_fall), 16'h016B);
		chk(16'(thresholds_out.ov_rise), 16'h016B);
	endtask

	// Software codes 12 V as 12 * 1024 / 40.96 = 300
	task automatic t_encode();
		logic [9:0] code;
		code = 10'(12 * 1024 * 100 / 4096);
		acc(1'b1, 1'b0, CTR_SEL_OV_RISE, 2'h3, {code, 6'h00});
		chk(16'(thresholds_out.ov_rise), 16'h012C);
		rd(CTR_SEL_OV_RISE, 16'h4B00);
	endtask

	// Write and read in one cycle: read sees the old word
	task automatic t_order();
		acc(1'b1, 1'b1, CTR_SEL_UV_FALL, 2'h3, 16'h1234);
		chk(rdata_out, 16'h5AC0);
		rd(CTR_SEL_UV_FALL, 16'h1200);
	endtask

	// Low lane only, then a refused write while running
	task automatic t_slope();
		acc(1'b1, 1'b0, CTR_SEL_SLOPE, 2'h3, 16'hA55A);
		acc(1'b1, 1'b0, CTR_SEL_SLOPE, 2'h1, 16'h0F3C);
		rd(CTR_SEL_SLOPE, 16'hA53C);
		conv_enabled_in = 1'b1;
		acc(1'b1, 1'b0, CTR_SEL_SLOPE, 2'h3, 16'h0000);
		chk(16'(wr_blocked_out), 16'h0001);
		chk(slope_comp_out, 16'hA53C);
		conv_enabled_in = 1'b0;
	endtask

	// Main sequence, with a second reset mid-run
	initial begin
		do_reset();
		t_defaults();
		t_thresholds();
		t_order();
		t_encode();
		t_slope();
		do_reset();
		t_defaults();
		test_done();
	end

	// Hang guard counts as a mismatch
	initial begin
		#100000;
		failures++;
		test_done();
	end
endmodule
